// ### eeprom_cmd_pkg.sv
package eeprom_cmd_pkg;

    // Field sizes of one instruction
    localparam int OPC_BITS  = 2;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 16;
    localparam int WORDS     = 256;

    // Bit counters inside a frame
    localparam logic [4:0] LAST_OPC  = 5'h01;
    localparam logic [4:0] LAST_ADDR = 5'h07;
    localparam logic [4:0] LAST_DATA = 5'h0f;

    // Opcode field values
    localparam logic [1:0] OP_READ    = 2'h2;
    localparam logic [1:0] OP_WRITE   = 2'h1;
    localparam logic [1:0] OP_ERASE   = 2'h3;
    localparam logic [1:0] OP_SPECIAL = 2'h0;

    // Sub-codes in the top address bits
    localparam logic [1:0] SUB_ENABLE  = 2'h3;
    localparam logic [1:0] SUB_FILL    = 2'h1;
    localparam logic [1:0] SUB_DISABLE = 2'h0;
    localparam logic [1:0] SUB_CLEAR   = 2'h2;

    // Data and status levels
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic        DUMMY_BIT   = 1'b0;
    localparam logic        BUSY_LEVEL  = 1'b0;
    localparam logic        READY_LEVEL = 1'b1;

    // Programming time
    localparam int TWP_MS     = 15;
    localparam int CLK_KHZ    = 40000;
    localparam int TWP_CYCLES = TWP_MS * CLK_KHZ;

    // Synchroniser lanes
    localparam int SY_CS    = 0;
    localparam int SY_CMD   = 1;
    localparam int SY_RD    = 2;
    localparam int SY_START = 3;
    localparam int SY_RDON  = 4;
    localparam int SY_BIT   = 5;
    localparam int SY_W     = 6;

    typedef struct packed {
        logic [1:0]  op;
        logic [7:0]  addr;
        logic [15:0] data;
    } cmd_t;

    typedef enum logic [2:0] {
        FS_WAIT   = 3'h0,
        FS_OPCODE = 3'h1,
        FS_ADDR   = 3'h2,
        FS_DATA   = 3'h3,
        FS_READ   = 3'h4,
        FS_DONE   = 3'h5
    } frame_state_t;

    typedef enum logic [2:0] {
        no_cmd              = 3'h0,
        read_cmd            = 3'h1,
        write_word_cmd      = 3'h2,
        erase_word_cmd      = 3'h3,
        program_enable_cmd  = 3'h4,
        fill_all_cmd        = 3'h5,
        program_disable_cmd = 3'h6,
        clear_all_cmd       = 3'h7
    } cmd_kind_t;

    // Opcode plus top address bits to instruction
    function automatic cmd_kind_t decode_cmd(input logic [1:0] op, input logic [1:0] sub);
        cmd_kind_t k;
        k = no_cmd;
        case (op)
            OP_READ:  k = read_cmd;
            OP_WRITE: k = write_word_cmd;
            OP_ERASE: k = erase_word_cmd;
            default: begin
                case (sub)
                    SUB_ENABLE:  k = program_enable_cmd;
                    SUB_FILL:    k = fill_all_cmd;
                    SUB_DISABLE: k = program_disable_cmd;
                    default:     k = clear_all_cmd;
                endcase
            end
        endcase
        return k;
    endfunction

endpackage

// ### eeprom_cmd_port.sv
// How it works
// - A frame begins only on the first one bit shifted in after select.
// - Zero bits before the start bit are ignored while waiting.
// - The two bits after the start bit are the opcode.
// - Eight address bits follow the opcode, most significant first.
// - Read, write and erase use all address bits; others use top two.
// - Opcodes 10, 01, 11 and sub-codes 11, 01, 00, 10 pick instructions.
// - Data words travel bit 15 first, bit 0 last, both directions.
// - Only word write and fill-all take a sixteen-bit data field.
// - Read loads the word, sends a dummy zero, then the sixteen bits.
// - Data-out changes after the rising serial clock edge.
// - Chip select fall ends a frame and starts programming.
// - Programming is disabled out of reset until enabled.
// - Enable persists until a disable instruction or reset.
// - Enable takes effect at chip select fall, not earlier.
// - Reads work whether programming is enabled or not.
// - Word write, erase, fill-all and clear-all act only while enabled.
// - While busy no new instruction is accepted.
// - While selected in status mode, low means busy, high means ready.
// - Status shows on data-out without any serial clock.
// - Fill-all writes the pattern into every word at once.
// - Data-in is sampled on each rising serial clock edge.
// - With select low all serial activity is ignored.
// - Data-out floats whenever select is low.
// - A start bit after ready returns data-out to high impedance.
module eeprom_cmd_port
    import eeprom_cmd_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = TWP_CYCLES
) (
    input  logic CLK,
    input  logic RESET,
    input  logic CHIP_SELECT,
    input  logic SERIAL_CLOCK_IN,
    input  logic SERIAL_DATA_IN,
    output logic SERIAL_DATA_OUT,
    output logic SERIAL_DATA_OUT_OE_N
);

    localparam int TW = $clog2(PROG_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////
    // Serial clock domain

    // Low select clears the frame logic
    logic         frame_rst;
    assign frame_rst = RESET | ~CHIP_SELECT;

    frame_state_t fstate_reg;
    frame_state_t fstate_next;
    logic [4:0]   cnt_reg;
    logic [4:0]   cnt_next;
    logic [15:0]  shift_reg;
    logic [15:0]  shift_next;
    logic [1:0]   op_reg;
    logic [1:0]   op_next;
    logic [7:0]   addr_reg;
    logic [7:0]   addr_next;
    logic         start_reg;
    logic         start_next;
    logic         rd_on_reg;
    logic         rd_on_next;
    logic         out_bit_reg;
    logic         out_bit_next;

    cmd_t         cmd_reg;
    cmd_t         cmd_next;
    logic         cmd_tog_reg;
    logic         cmd_tog_next;
    logic [7:0]   rd_addr_reg;
    logic [7:0]   rd_addr_next;
    logic         rd_tog_reg;
    logic         rd_tog_next;

    logic [15:0]  rd_word_reg;
    cmd_kind_t    addr_kind;
    logic         last_addr;
    logic         last_data;

    // Incoming bit joins the shift register
    assign shift_next = {shift_reg[14:0], SERIAL_DATA_IN};
    assign addr_kind  = decode_cmd(op_reg, shift_next[7:6]);
    assign last_addr  = (fstate_reg == FS_ADDR) && (cnt_reg == LAST_ADDR);
    assign last_data  = (fstate_reg == FS_DATA) && (cnt_reg == LAST_DATA);

    // Frame sequencer
    always_comb begin
        fstate_next  = fstate_reg;
        cnt_next     = cnt_reg + 5'h01;
        op_next      = op_reg;
        addr_next    = addr_reg;
        start_next   = start_reg;
        rd_on_next   = rd_on_reg;
        out_bit_next = out_bit_reg;
        case (fstate_reg)
            FS_WAIT: begin
                cnt_next = 5'h00;
                if (SERIAL_DATA_IN) begin
                    start_next  = 1'b1;
                    fstate_next = FS_OPCODE;
                end
            end
            FS_OPCODE: begin
                if (cnt_reg == LAST_OPC) begin
                    op_next     = shift_next[1:0];
                    cnt_next    = 5'h00;
                    fstate_next = FS_ADDR;
                end
            end
            FS_ADDR: begin
                if (last_addr) begin
                    addr_next = shift_next[7:0];
                    cnt_next  = 5'h00;
                    case (addr_kind)
                        read_cmd: begin
                            fstate_next  = FS_READ;
                            rd_on_next   = 1'b1;
                            out_bit_next = DUMMY_BIT;
                        end
                        write_word_cmd, fill_all_cmd: begin
                            fstate_next = FS_DATA;
                        end
                        default: begin
                            fstate_next = FS_DONE;
                        end
                    endcase
                end
            end
            FS_DATA: begin
                if (last_data) begin
                    fstate_next = FS_DONE;
                end
            end
            FS_READ: begin
                if (!cnt_reg[4]) begin
                    out_bit_next = rd_word_reg[~cnt_reg[3:0]];
                end else begin
                    fstate_next = FS_DONE;
                    rd_on_next  = 1'b0;
                    cnt_next    = cnt_reg;
                end
            end
            FS_DONE: begin
                cnt_next = cnt_reg;
            end
            default: begin
                fstate_next = FS_WAIT;
            end
        endcase
    end

    always_ff @(posedge SERIAL_CLOCK_IN or posedge frame_rst) begin
        if (frame_rst) begin
            fstate_reg  <= FS_WAIT;
            cnt_reg     <= 5'h00;
            shift_reg   <= 16'h0000;
            op_reg      <= 2'h0;
            addr_reg    <= 8'h00;
            start_reg   <= 1'b0;
            rd_on_reg   <= 1'b0;
            out_bit_reg <= 1'b0;
        end else begin
            fstate_reg  <= fstate_next;
            cnt_reg     <= cnt_next;
            shift_reg   <= shift_next;
            op_reg      <= op_next;
            addr_reg    <= addr_next;
            start_reg   <= start_next;
            rd_on_reg   <= rd_on_next;
            out_bit_reg <= out_bit_next;
        end
    end

    // Completed instructions, kept across deselect
    always_comb begin
        cmd_next     = cmd_reg;
        cmd_tog_next = cmd_tog_reg;
        rd_addr_next = rd_addr_reg;
        rd_tog_next  = rd_tog_reg;
        if (last_data) begin
            cmd_next     = '{op: op_reg, addr: addr_reg, data: shift_next};
            cmd_tog_next = ~cmd_tog_reg;
        end else if (last_addr) begin
            case (addr_kind)
                read_cmd: begin
                    rd_addr_next = shift_next[7:0];
                    rd_tog_next  = ~rd_tog_reg;
                end
                write_word_cmd, fill_all_cmd: begin
                    cmd_next = cmd_reg;
                end
                default: begin
                    cmd_next     = '{op: op_reg, addr: shift_next[7:0], data: 16'h0000};
                    cmd_tog_next = ~cmd_tog_reg;
                end
            endcase
        end
    end

    always_ff @(posedge SERIAL_CLOCK_IN or posedge RESET) begin
        if (RESET) begin
            cmd_reg     <= '0;
            cmd_tog_reg <= 1'b0;
            rd_addr_reg <= 8'h00;
            rd_tog_reg  <= 1'b0;
        end else begin
            cmd_reg     <= cmd_next;
            cmd_tog_reg <= cmd_tog_next;
            rd_addr_reg <= rd_addr_next;
            rd_tog_reg  <= rd_tog_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossing into the system clock

    logic [SY_W-1:0] async_in;
    logic [SY_W-1:0] sync_out;

    assign async_in[SY_CS]    = CHIP_SELECT;
    assign async_in[SY_CMD]   = cmd_tog_reg;
    assign async_in[SY_RD]    = rd_tog_reg;
    assign async_in[SY_START] = start_reg;
    assign async_in[SY_RDON]  = rd_on_reg;
    assign async_in[SY_BIT]   = out_bit_reg;

    // Three stages; a change counts when the last two agree
    for (genvar b = 0; b < SY_W; b++) begin : g_sync
        logic s1_reg;
        logic s2_reg;
        logic s3_reg;
        logic stable_reg;
        logic stable_next;
        assign stable_next = (s2_reg == s3_reg) ? s3_reg : stable_reg;
        always_ff @(posedge CLK or posedge RESET) begin
            if (RESET) begin
                s1_reg     <= 1'b0;
                s2_reg     <= 1'b0;
                s3_reg     <= 1'b0;
                stable_reg <= 1'b0;
            end else begin
                s1_reg     <= async_in[b];
                s2_reg     <= s1_reg;
                s3_reg     <= s2_reg;
                stable_reg <= stable_next;
            end
        end
        assign sync_out[b] = stable_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Array and programming control

    logic [15:0]   mem_reg [WORDS];
    logic [15:0]   mem_next [WORDS];
    logic          prog_go;
    logic          prog_all;
    logic [15:0]   prog_val;
    cmd_kind_t     kind;

    logic          cs_d_reg;
    logic          cs_d_next;
    logic          fall_reg;
    logic          fall_next;
    logic          cmd_seen_reg;
    logic          cmd_seen_next;
    logic          rd_seen_reg;
    logic          rd_seen_next;
    logic          wen_reg;
    logic          wen_next;
    logic          busy_reg;
    logic          busy_next;
    logic          status_reg;
    logic          status_next;
    logic [TW-1:0] timer_reg;
    logic [TW-1:0] timer_next;
    logic [15:0]   rd_word_next;
    logic          do_reg;
    logic          do_next;
    logic          oe_n_reg;
    logic          oe_n_next;

    assign kind = decode_cmd(cmd_reg.op, cmd_reg.addr[7:6]);

    // Every word takes its next value; fill and clear hit all at once
    for (genvar g = 0; g < WORDS; g++) begin : g_word
        assign mem_next[g] = (prog_go && (prog_all || cmd_reg.addr == 8'(g)))
                             ? prog_val : mem_reg[g];
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_reg[i] <= ERASED_WORD;
            end
        end else begin
            mem_reg <= mem_next;
        end
    end

    // Instruction execution, busy timer, status and pin drive
    always_comb begin
        cs_d_next     = sync_out[SY_CS];
        fall_next     = cs_d_reg & ~sync_out[SY_CS];
        cmd_seen_next = fall_reg ? sync_out[SY_CMD] : cmd_seen_reg;
        rd_seen_next  = sync_out[SY_RD];
        rd_word_next  = rd_word_reg;
        wen_next      = wen_reg;
        busy_next     = busy_reg;
        status_next   = status_reg;
        timer_next    = timer_reg;
        prog_go       = 1'b0;
        prog_all      = (kind == fill_all_cmd) || (kind == clear_all_cmd);
        prog_val      = ((kind == write_word_cmd) || (kind == fill_all_cmd))
                        ? cmd_reg.data : ERASED_WORD;
        // Read word is fetched between serial edges
        if ((sync_out[SY_RD] != rd_seen_reg) && !busy_reg) begin
            rd_word_next = mem_reg[rd_addr_reg];
        end
        // Busy countdown
        if (busy_reg) begin
            if (timer_reg == '0) begin
                busy_next = 1'b0;
            end else begin
                timer_next = timer_reg - TW'(1);
            end
        end
        // Start bit after ready drops the status display
        if (status_reg && !busy_reg && sync_out[SY_START]) begin
            status_next = 1'b0;
        end
        // Act on a full instruction at select fall
        if (fall_reg && (sync_out[SY_CMD] != cmd_seen_reg) && !busy_reg) begin
            case (kind)
                program_enable_cmd: begin
                    wen_next = 1'b1;
                end
                program_disable_cmd: begin
                    wen_next = 1'b0;
                end
                write_word_cmd, erase_word_cmd, fill_all_cmd, clear_all_cmd: begin
                    prog_go = wen_reg;
                end
                default: begin
                    prog_go = 1'b0;
                end
            endcase
        end
        if (prog_go) begin
            busy_next   = 1'b1;
            status_next = 1'b1;
            timer_next  = TW'(PROG_CYCLES - 1);
        end
        // Pin drive: float when deselected
        if (!sync_out[SY_CS]) begin
            oe_n_next = 1'b1;
            do_next   = 1'b0;
        end else if (status_reg) begin
            oe_n_next = 1'b0;
            do_next   = busy_reg ? BUSY_LEVEL : READY_LEVEL;
        end else if (sync_out[SY_RDON]) begin
            oe_n_next = 1'b0;
            do_next   = sync_out[SY_BIT];
        end else begin
            oe_n_next = 1'b1;
            do_next   = 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cs_d_reg     <= 1'b0;
            fall_reg     <= 1'b0;
            cmd_seen_reg <= 1'b0;
            rd_seen_reg  <= 1'b0;
            rd_word_reg  <= 16'h0000;
            wen_reg      <= 1'b0; // Programming starts disabled
            busy_reg     <= 1'b0;
            status_reg   <= 1'b0;
            timer_reg    <= '0;
            do_reg       <= 1'b0;
            oe_n_reg     <= 1'b1;
        end else begin
            cs_d_reg     <= cs_d_next;
            fall_reg     <= fall_next;
            cmd_seen_reg <= cmd_seen_next;
            rd_seen_reg  <= rd_seen_next;
            rd_word_reg  <= rd_word_next;
            wen_reg      <= wen_next;
            busy_reg     <= busy_next;
            status_reg   <= status_next;
            timer_reg    <= timer_next;
            do_reg       <= do_next;
            oe_n_reg     <= oe_n_next;
        end
    end

    assign SERIAL_DATA_OUT      = do_reg;
    assign SERIAL_DATA_OUT_OE_N = oe_n_reg;

endmodule

// ### eeprom_cmd_port_checker.sv
module eeprom_cmd_port_checker
    import eeprom_cmd_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = TWP_CYCLES
) (
    input logic CLK,
    input logic RESET,
    input logic CHIP_SELECT,
    input logic SERIAL_CLOCK_IN,
    input logic SERIAL_DATA_IN,
    input logic SERIAL_DATA_OUT,
    input logic SERIAL_DATA_OUT_OE_N
);
    logic        sk_q_reg, sk_q_next;
    logic        cs_q_reg, cs_q_next;
    logic        quiet_reg, quiet_next;
    logic [31:0] sk_age_reg, sk_age_next;
    logic        sk_rise;

    ////////////////////////////////////////////////////////////////////////
    // Quiet means selected with no serial clock yet: status polling
    always_comb begin
        sk_rise     = SERIAL_CLOCK_IN && !sk_q_reg;
        sk_q_next   = SERIAL_CLOCK_IN;
        cs_q_next   = CHIP_SELECT;
        sk_age_next = sk_rise ? 32'h0 : sk_age_reg + {31'h0, ~&sk_age_reg};
        quiet_next  = (CHIP_SELECT && !cs_q_reg) ? 1'h1 : (sk_rise ? 1'h0 : quiet_reg);
    end

    // Helper registers
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sk_q_reg   <= 1'h0;
            cs_q_reg   <= 1'h0;
            quiet_reg  <= 1'h0;
            sk_age_reg <= 32'h0;
        end else begin
            sk_q_reg   <= sk_q_next;
            cs_q_reg   <= cs_q_next;
            quiet_reg  <= quiet_next;
            sk_age_reg <= sk_age_next;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    ////////////////////////////////////////////////////////////////////////
    reset_idle_a: assert property ($fell(RESET) |-> SERIAL_DATA_OUT_OE_N && !SERIAL_DATA_OUT)
        else $error("Output not idle after reset");
    float_deselect_a: assert property (!CHIP_SELECT [*8] |-> SERIAL_DATA_OUT_OE_N)
        else $error("Output driven while deselected");
    release_quick_a: assert property ($fell(CHIP_SELECT) |-> ##[1:8] SERIAL_DATA_OUT_OE_N)
        else $error("Output not released after deselect");
    drive_selected_a: assert property ($fell(SERIAL_DATA_OUT_OE_N) |-> $past(CHIP_SELECT, 2))
        else $error("Output driven without select");
    out_on_sk_a: assert property ($changed(SERIAL_DATA_OUT) && !SERIAL_DATA_OUT_OE_N &&
        !$past(SERIAL_DATA_OUT_OE_N) && !quiet_reg |-> sk_age_reg <= 32'h8)
        else $error("Data out changed away from serial clock");
    ready_late_a: assert property ($rose(SERIAL_DATA_OUT) && !SERIAL_DATA_OUT_OE_N &&
        !$past(SERIAL_DATA_OUT_OE_N) && quiet_reg |-> sk_age_reg >= PROG_CYCLES)
        else $error("Ready shown before programming time");
    status_stands_a: assert property (quiet_reg && CHIP_SELECT && !SERIAL_DATA_OUT_OE_N
        |=> !SERIAL_DATA_OUT_OE_N)
        else $error("Status dropped without serial clock");
    ready_holds_a: assert property (quiet_reg && CHIP_SELECT && !SERIAL_DATA_OUT_OE_N &&
        SERIAL_DATA_OUT |=> SERIAL_DATA_OUT)
        else $error("Ready status fell back");
    start_clears_a: assert property (quiet_reg && !SERIAL_DATA_OUT_OE_N && SERIAL_DATA_OUT
        && sk_rise && SERIAL_DATA_IN |-> ##[1:8] SERIAL_DATA_OUT_OE_N)
        else $error("Start bit did not clear ready status");

    // Main scenarios
    read_data_c: cover property (!SERIAL_DATA_OUT_OE_N && !quiet_reg && SERIAL_DATA_OUT);
    busy_shown_c: cover property (quiet_reg && !SERIAL_DATA_OUT_OE_N && !SERIAL_DATA_OUT);
    ready_shown_c: cover property (quiet_reg && !SERIAL_DATA_OUT_OE_N && SERIAL_DATA_OUT);
endmodule

bind eeprom_cmd_port eeprom_cmd_port_checker #(.PROG_CYCLES(PROG_CYCLES)) port_chk (
    .CLK                  (CLK),
    .RESET                (RESET),
    .CHIP_SELECT          (CHIP_SELECT),
    .SERIAL_CLOCK_IN      (SERIAL_CLOCK_IN),
    .SERIAL_DATA_IN       (SERIAL_DATA_IN),
    .SERIAL_DATA_OUT      (SERIAL_DATA_OUT),
    .SERIAL_DATA_OUT_OE_N (SERIAL_DATA_OUT_OE_N)
);

// ### serial_master.sv
module serial_master
    import eeprom_cmd_pkg::*;
#(
    parameter int GAP = 80
) (
    input  logic clk,
    input  logic data_out_wire,
    output logic cs,
    output logic sk,
    output logic di
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial begin
        cs = 1'h0;
        sk = 1'h0;
        di = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One bit: data set up, reply sampled, then a 15 ns clock pulse
    task automatic shift_bit(input logic b, output logic s);
        di = b;
        repeat (GAP) @(negedge clk);
        s = data_out_wire;
        sk = 1'h1;
        #15 sk = 1'h0;
        repeat (GAP) @(negedge clk);
    endtask

    // Whole instruction, all n bits MSB first, then deselect
    task automatic frame(input logic [31:0] bits, input int n, output logic [16:0] rd);
        logic s;
        rd = '0;
        @(negedge clk);
        cs = 1'h1;
        for (int i = n - 1; i >= 0; i--) begin
            shift_bit(bits[i], s);
            rd = {rd[15:0], s};
        end
        cs = 1'h0;
        di = ~di;
        repeat (GAP) @(negedge clk);
    endtask

    // Select without clocking and sample the status
    task automatic poll(input int n, output logic s);
        @(negedge clk);
        cs = 1'h1;
        repeat (n) @(negedge clk);
        s = data_out_wire;
    endtask
endmodule

// ### serial_eeprom_command_port_tb.sv
module serial_eeprom_command_port_tb
    import eeprom_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned PROG = 400;

    logic        clk, reset, cs, sk, di, do_pin, oe_n;
    wire         do_wire;
    int          errors, n_compared, cycles, seed;
    logic [15:0] shadow [WORDS];
    logic [7:0]  a;
    logic [15:0] d;

    assign do_wire = oe_n ? 1'hz : do_pin;

    eeprom_cmd_port #(.PROG_CYCLES(PROG)) DUT (
        .CLK                  (clk),
        .RESET                (reset),
        .CHIP_SELECT          (cs),
        .SERIAL_CLOCK_IN      (sk),
        .SERIAL_DATA_IN       (di),
        .SERIAL_DATA_OUT      (do_pin),
        .SERIAL_DATA_OUT_OE_N (oe_n)
    );

    serial_master M (
        .clk           (clk),
        .data_out_wire (do_wire),
        .cs            (cs),
        .sk            (sk),
        .di            (di)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and timeout
    always #12.5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] make_frame(input logic [1:0] op, input logic [7:0] ad,
                                               input logic [15:0] dw);
        return {5'h00, 1'h1, op, ad, dw};
    endfunction

    task automatic check_word(input logic [16:0] exp, input logic [16:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic check_bit(input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    // Instruction of full length for its kind
    task automatic send(input logic [1:0] op, input logic [7:0] ad, input logic [15:0] dw);
        logic [16:0] rd;
        if (op == OP_WRITE || (op == OP_SPECIAL && ad[7:6] == SUB_FILL))
            M.frame(make_frame(op, ad, dw), 27, rd);
        else
            M.frame(make_frame(op, ad, dw) >> 16, 11, rd);
    endtask

    // Read with z leading zeros (at most four): dummy bit then the word
    task automatic read_check(input logic [7:0] ad, input int z = 2);
        logic [16:0] rd;
        M.frame(make_frame(OP_READ, ad, 16'h0000) << 1, 28 + z, rd);
        check_word({DUMMY_BIT, shadow[ad]}, rd);
    endtask

    // Programming instruction, status poll, expected array update
    task automatic prog_run(input logic [1:0] op, input logic [7:0] ad, input logic [15:0] dw,
                            input logic on);
        logic s;
        int   n;
        send(op, ad, dw);
        M.poll(8, s);
        check_bit(on ? BUSY_LEVEL : 1'hz, s);
        n = 0;
        while (on && s !== READY_LEVEL && n < PROG + 40) begin
            @(negedge clk);
            s = do_wire;
            n++;
        end
        if (on) check_bit(READY_LEVEL, s);
        if (on && op == OP_WRITE) shadow[ad] = dw;
        if (on && op == OP_ERASE) shadow[ad] = ERASED_WORD;
        if (on && op == OP_SPECIAL)
            for (int i = 0; i < WORDS; i++)
                shadow[i] = (ad[7:6] == SUB_FILL) ? dw : ERASED_WORD;
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk = 1'h0;
        reset = 1'h1;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        seed = 19;
        for (int i = 0; i < WORDS; i++)
            shadow[i] = ERASED_WORD;
        repeat (12) @(negedge clk);
        reset = 1'h0;
        repeat (6) @(negedge clk);
        a = 8'($random(seed));
        read_check(a);
        prog_run(OP_WRITE, a, 16'h5a5a, 1'h0);
        read_check(a);
        send(OP_SPECIAL, {SUB_ENABLE, 6'h2a}, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            a = k ? 8'hff : 8'h00;
            d = 16'($random(seed));
            prog_run(OP_WRITE, a, d, 1'h1);
            read_check(a, 0);
        end
        prog_run(OP_ERASE, a, 16'h0000, 1'h1);
        read_check(a);
        prog_run(OP_SPECIAL, {SUB_FILL, 6'h15}, 16'($random(seed)), 1'h1);
        read_check(8'($random(seed)));
        prog_run(OP_SPECIAL, {SUB_CLEAR, 6'h00}, 16'h0000, 1'h1);
        read_check(8'h7e);
        send(OP_SPECIAL, {SUB_DISABLE, 6'h3f}, 16'h0000);
        prog_run(OP_WRITE, 8'h7e, 16'h0f0f, 1'h0);
        read_check(8'h7e);
        finish_test();
    end
endmodule
